// [rtl/fade_sequencer.sv]
// Shutdown fade and wakeup ramp sequencer with its registers.
`timescale 1ns/1ps
`include "fade_defs.svh"
module fade_sequencer #(
  parameter int INT_OSC_DIV = `INT_OSC_DIV
) (
  // Clock and reset.
  input wire logic sys_clk_in,
  input wire logic rst_n_in,
  // Decoded serial command word and read-back byte.
  input wire logic cmd_strobe_in,
  input wire logic [15:0] cmd_word_in,
  output logic [7:0] rd_data_out,
  // PWM clock sources and wakeup.
  input wire logic serial_out_or_clock_in_pin_in,
  input wire logic cs_wake_in,
  input wire logic pwm_in_use_in,
  // Current reference and power control.
  output logic [2:0] fade_dac_out,
  output logic shutdown_out,
  output logic osc_run_out
);
  import fade_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // State.

  // All sequencer state in one record.
  typedef struct packed {
    seq_state_e state; // Sequencer phase.
    logic [2:0] level; // Ramp position before capping.
    logic [2:0] dac; // Capped DAC drive.
    logic shut; // Shutdown output.
    logic osc_run; // Internal oscillator enable.
    logic run; // Config run bit.
    logic cswake; // Chip-select wakeup enable.
    logic rampen; // Ramp-up on restart enable.
    logic osc_ext; // External PWM clock selected.
    logic [5:0] ramp_down; // Hold and fade codes.
    code_t ramp_up; // Ramp-up code.
    logic [2:0] iset; // Global current.
    logic [7:0] rd; // Read-back byte.
    logic [2:0] sync; // Pin synchroniser.
    logic ext_lvl; // Filtered pin level.
    logic [11:0] pre; // Internal oscillator divider.
    logic tick; // PWM tick.
  } seq_s;

  seq_s r_reg; // Registered state.
  seq_s r_next; // Next state.

  phase_timer_if tif ();

  // Timer instance.
  phase_timer u_timer (
    .sys_clk_in(sys_clk_in),
    .rst_n_in(rst_n_in),
    .tmr(tif.timer)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Decode and timing helpers.

  logic wr_en; // Write command.
  logic rd_en; // Read command.
  logic [6:0] addr; // Addressed register.
  logic [7:0] wdata; // Write data.
  code_t hold_code; // Hold-off code.
  code_t fade_code; // Fade-off code.
  code_t phase_code; // Code of current phase.

  assign wr_en = cmd_strobe_in && !cmd_word_in[`CMD_RW_BIT];
  assign rd_en = cmd_strobe_in && cmd_word_in[`CMD_RW_BIT];
  assign addr = cmd_word_in[`CMD_ADDR_HI:`CMD_ADDR_LO];
  assign wdata = cmd_word_in[7:0];
  assign hold_code = r_reg.ramp_down[`RD_HOLD_HI:`RD_HOLD_LO];
  assign fade_code = r_reg.ramp_down[`RD_FADE_HI:`RD_FADE_LO];

  // Pick the code that times the present phase.
  always_comb begin
    if (r_reg.state == ST_HOLD) begin
      phase_code = hold_code;
    end else if (r_reg.state == ST_FADE) begin
      phase_code = fade_code;
    end else begin
      phase_code = r_reg.ramp_up;
    end
  end

  // Hold-off lasts the whole duration; fade and ramp intervals are an eighth.
  always_comb begin
    if (phase_code == `CODE_OFF) begin
      tif.target = 18'h00001;
    end else if (r_reg.state == ST_HOLD) begin
      tif.target = 18'(`BASE_TICKS) << (phase_code - 3'h1);
    end else begin
      tif.target = 18'(`STEP_TICKS) << (phase_code - 3'h1);
    end
  end

  assign tif.tick = r_reg.tick;
  assign tif.load = (r_next.state != r_reg.state);

  ////////////////////////////////////////////////////////////////////////////
  // Next-state logic.

  // Registers, PWM tick, sequencer and outputs.
  always_comb begin
    r_next = r_reg;
    // Three-stage pin synchroniser; level taken once stages two and three agree.
    r_next.sync = {r_reg.sync[1:0], serial_out_or_clock_in_pin_in};
    if (r_reg.sync[1] == r_reg.sync[2]) begin
      r_next.ext_lvl = r_reg.sync[2];
    end
    // Internal oscillator divider runs only while enabled.
    if (r_reg.osc_run && r_reg.pre != 12'(INT_OSC_DIV - 1)) begin
      r_next.pre = r_reg.pre + 12'h001;
    end else begin
      r_next.pre = 12'h000;
    end
    if (r_reg.osc_ext) begin
      // External clock must keep toggling until the phase ends.
      r_next.tick = r_next.ext_lvl && !r_reg.ext_lvl;
    end else begin
      r_next.tick = r_reg.osc_run && (r_reg.pre == 12'(INT_OSC_DIV - 1));
    end
    // Register writes; unused upper bits are dropped.
    if (wr_en) begin
      if (addr == `ADDR_CFG) begin
        r_next.run = wdata[`CFG_RUN_BIT];
        r_next.cswake = wdata[`CFG_CSWAKE_BIT];
        r_next.rampen = wdata[`CFG_RAMPEN_BIT];
        r_next.osc_ext = wdata[`CFG_OSC_EXT_BIT];
      end else if (addr == `ADDR_RAMP_DOWN) begin
        r_next.ramp_down = wdata[5:0];
      end else if (addr == `ADDR_RAMP_UP) begin
        r_next.ramp_up = wdata[2:0];
      end else if (addr == `ADDR_GLOBAL) begin
        r_next.iset = wdata[2:0];
      end
    end
    // Chip-select pulse wakes the device when enabled.
    if (cs_wake_in && r_reg.cswake && r_reg.state == ST_SHUT) begin
      r_next.run = 1'b1;
    end
    // Sequencer.
    case (r_reg.state)
      ST_RUN, ST_RAMP: begin
        if (!r_next.run) begin
          // Shutdown request: skip empty phases.
          if (hold_code != `CODE_OFF) begin
            r_next.state = ST_HOLD;
            r_next.level = `DAC_FULL;
          end else if (fade_code != `CODE_OFF) begin
            r_next.state = ST_FADE;
            r_next.level = `DAC_FULL;
          end else begin
            r_next.state = ST_SHUT;
            r_next.level = `DAC_ZERO;
          end
        end else if (r_reg.state == ST_RAMP && tif.done) begin
          if (r_reg.level == `DAC_FULL) begin
            r_next.state = ST_RUN;
          end else begin
            r_next.level = r_reg.level + 3'h1;
          end
        end
      end
      ST_HOLD, ST_FADE, ST_SHUT: begin
        if (r_next.run) begin
          // Restart: ramp from present level, or jump to full current.
          if (r_next.rampen && r_reg.ramp_up != `CODE_OFF) begin
            r_next.state = ST_RAMP;
          end else begin
            r_next.state = ST_RUN;
            r_next.level = `DAC_FULL;
          end
        end else if (r_reg.state == ST_HOLD && tif.done) begin
          if (fade_code != `CODE_OFF) begin
            r_next.state = ST_FADE;
          end else begin
            r_next.state = ST_SHUT;
            r_next.level = `DAC_ZERO;
          end
        end else if (r_reg.state == ST_FADE && tif.done) begin
          if (r_reg.level == `DAC_ZERO) begin
            r_next.state = ST_SHUT;
          end else begin
            r_next.level = r_reg.level - 3'h1;
          end
        end
      end
      default: begin
        r_next.state = ST_SHUT;
      end
    endcase
    // Master reference DAC, capped by global current; all outputs scale alike.
    r_next.dac = (r_next.level < r_next.iset) ? r_next.level : r_next.iset;
    r_next.shut = (r_next.state == ST_SHUT);
    // Oscillator kept alive through every timed phase.
    r_next.osc_run = pwm_in_use_in || (r_next.state != ST_RUN && r_next.state != ST_SHUT);
    // Read-back with zeroed upper bits and live status.
    if (rd_en) begin
      if (addr == `ADDR_CFG) begin
        r_next.rd = 8'h00;
        r_next.rd[`CFG_RUN_BIT] = r_reg.run;
        r_next.rd[`CFG_CSWAKE_BIT] = r_reg.cswake;
        r_next.rd[`CFG_RAMPEN_BIT] = r_reg.rampen;
        r_next.rd[`CFG_ST_HOLD_BIT] = (r_reg.state == ST_HOLD);
        r_next.rd[`CFG_ST_FADE_BIT] = (r_reg.state == ST_FADE);
        r_next.rd[`CFG_ST_RAMP_BIT] = (r_reg.state == ST_RAMP);
        r_next.rd[`CFG_OSC_EXT_BIT] = r_reg.osc_ext;
      end else if (addr == `ADDR_RAMP_DOWN) begin
        r_next.rd = {2'h0, r_reg.ramp_down};
      end else if (addr == `ADDR_RAMP_UP) begin
        r_next.rd = {5'h00, r_reg.ramp_up};
      end else if (addr == `ADDR_GLOBAL) begin
        r_next.rd = {5'h00, r_reg.iset};
      end else begin
        r_next.rd = 8'h00;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Registers and outputs.

  // State register; device starts in shutdown.
  always_ff @(posedge sys_clk_in) begin
    if (!rst_n_in) begin
      r_reg <= '0;
      r_reg.state <= ST_SHUT;
      r_reg.shut <= 1'b1;
      r_reg.iset <= `GLOBAL_RESET;
      r_reg.ramp_down <= `RAMP_DOWN_RESET;
      r_reg.ramp_up <= `RAMP_UP_RESET;
    end else begin
      r_reg <= r_next;
    end
  end

  assign rd_data_out = r_reg.rd;
  assign fade_dac_out = r_reg.dac;
  assign shutdown_out = r_reg.shut;
  assign osc_run_out = r_reg.osc_run;

  ////////////////////////////////////////////////////////////////////////////
  // Assertions.

  default clocking cb @(posedge sys_clk_in); endclocking
  default disable iff (!rst_n_in);

  // Hold-off keeps the DAC at the capped full level.
  a_hold_full_level: assert property (
    r_reg.state == ST_HOLD |-> fade_dac_out == r_reg.iset)
    else $error("Hold-off not at full current.");
  // The DAC never rises above the global current.
  a_dac_cap_global: assert property (
    fade_dac_out <= r_reg.iset)
    else $error("Fade DAC above global current.");
  // A zero fade code shuts down straight after hold-off.
  a_fade_zero_shut: assert property (
    r_reg.state == ST_HOLD && tif.done && fade_code == `CODE_OFF && !r_next.run
    |=> r_reg.state == ST_SHUT && fade_dac_out == `DAC_ZERO)
    else $error("Fade code zero did not shut down.");
  // A zero hold code goes from run straight into the fade.
  a_hold_zero_skip: assert property (
    r_reg.state == ST_RUN && wr_en && addr == `ADDR_CFG && !wdata[`CFG_RUN_BIT]
    && hold_code == `CODE_OFF && fade_code != `CODE_OFF |=> r_reg.state == ST_FADE)
    else $error("Hold code zero did not skip hold-off.");
  // A zero ramp code restores the capped full level at once.
  a_ramp_instant_full: assert property (
    r_reg.state == ST_SHUT && wr_en && addr == `ADDR_CFG && wdata[`CFG_RUN_BIT]
    && r_reg.ramp_up == `CODE_OFF |=> r_reg.state == ST_RUN && fade_dac_out == r_reg.iset)
    else $error("Ramp code zero not instant.");
  // Status bits of a read show the phase at the strobe edge.
  a_status_bits: assert property (
    rd_en && addr == `ADDR_CFG |=> rd_data_out[`CFG_ST_RAMP_BIT:`CFG_ST_HOLD_BIT] ==
    {$past(r_reg.state) == ST_RAMP, $past(r_reg.state) == ST_FADE,
     $past(r_reg.state) == ST_HOLD})
    else $error("Status bits do not match phase.");
  // The oscillator runs through every timed phase.
  a_osc_kept_on: assert property (
    r_reg.state inside {ST_HOLD, ST_FADE, ST_RAMP} |-> osc_run_out)
    else $error("Oscillator stopped during sequence.");
  // Each fade interval lowers the level by one.
  a_fade_step_down: assert property (
    r_reg.state == ST_FADE && tif.done && r_reg.level != `DAC_ZERO && !r_next.run
    |=> r_reg.level == $past(r_reg.level) - 3'h1)
    else $error("Fade did not step down one level.");
  // Each ramp interval raises the level by one.
  a_ramp_step_up: assert property (
    r_reg.state == ST_RAMP && tif.done && r_reg.level != `DAC_FULL && r_next.run
    |=> r_reg.level == $past(r_reg.level) + 3'h1)
    else $error("Ramp did not step up one level.");
  // The last ramp interval ends in run at the capped full level.
  a_ramp_end_run: assert property (
    r_reg.state == ST_RAMP && tif.done && r_reg.level == `DAC_FULL && r_next.run
    |=> r_reg.state == ST_RUN && fade_dac_out == r_reg.iset)
    else $error("Ramp did not end at full current.");
  // Unused upper bits read back as zero.
  a_ramp_up_read: assert property (
    rd_en && addr == `ADDR_RAMP_UP |=> rd_data_out[7:3] == 5'h00)
    else $error("Ramp-up read upper bits not zero.");
  a_ramp_down_read: assert property (
    rd_en && addr == `ADDR_RAMP_DOWN |=> rd_data_out[7:6] == 2'h0)
    else $error("Ramp-down read upper bits not zero.");
endmodule

// [rtl/fade_defs.svh]
// Register addresses, field positions, reset values and timing counts of the fade sequencer.
// Operation
// - Ramp-down register at 0x11, hold/fade codes.
// - Fade code zero shuts down instantly, else ramps.
// - Hold code zero skips delay, else 1/16s-4s.
// - Ramp-up register at 0x12, upper bits zero.
// - Ramp code zero restores full current instantly.
// - All durations count PWM clock ticks.
// - Internal oscillator runs throughout any fade.
// - Sequencer drives 3-bit master reference DAC.
// - All outputs scale by same ratio.
// - Global current caps the fade DAC level.
// - Config register shows hold, fade, ramp status.
// - One config write requests shutdown and options.
// - Zero codes give zero-duration phases.
// - Hold-off keeps full programmed current.
`ifndef FADE_DEFS_SVH
`define FADE_DEFS_SVH

// Register addresses on the serial command word.
`define ADDR_CFG 7'h10
`define ADDR_RAMP_DOWN 7'h11
`define ADDR_RAMP_UP 7'h12
`define ADDR_GLOBAL 7'h15

// Command word fields.
`define CMD_RW_BIT 15
`define CMD_ADDR_HI 14
`define CMD_ADDR_LO 8

// Configuration register bit positions.
`define CFG_RUN_BIT 0
`define CFG_CSWAKE_BIT 1
`define CFG_RAMPEN_BIT 2
`define CFG_ST_HOLD_BIT 3
`define CFG_ST_FADE_BIT 4
`define CFG_ST_RAMP_BIT 5
`define CFG_OSC_EXT_BIT 7

// Ramp-down field positions.
`define RD_HOLD_HI 5
`define RD_HOLD_LO 3
`define RD_FADE_HI 2
`define RD_FADE_LO 0

// Reset values.
`define CFG_RESET 8'h00
`define RAMP_DOWN_RESET 6'h00
`define RAMP_UP_RESET 3'h0
`define GLOBAL_RESET 3'h7

// DAC levels and codes.
`define DAC_FULL 3'h7
`define DAC_ZERO 3'h0
`define CODE_OFF 3'h0

// Timing: PWM clock rate, shortest duration of 1/16 s, eight DAC steps.
`define SYS_HZ 100000000
`define PWM_HZ 32768
`define BASE_TIME_DIV 16
`define BASE_TICKS (`PWM_HZ / `BASE_TIME_DIV)
`define DAC_STEPS 8
`define STEP_TICKS (`BASE_TICKS / `DAC_STEPS)
`define INT_OSC_DIV (`SYS_HZ / `PWM_HZ)

`endif

// [rtl/fade_pkg.sv]
// Types shared by the fade sequencer modules.
package fade_pkg;
  // Sequencer states, one-hot.
  typedef enum logic [4:0] {
    ST_RUN = 5'h01,
    ST_HOLD = 5'h02,
    ST_FADE = 5'h04,
    ST_SHUT = 5'h08,
    ST_RAMP = 5'h10
  } seq_state_e;
  // Duration code and tick count types.
  typedef logic [2:0] code_t;
  typedef logic [17:0] ticks_t;
endpackage

// [rtl/phase_timer_if.sv]
// Connection between the sequencer and its phase timer.
`timescale 1ns/1ps
interface phase_timer_if;
  import fade_pkg::*;
  logic load; // Restarts the count.
  logic tick; // One PWM clock period elapsed.
  ticks_t target; // Ticks per interval.
  logic done; // Interval complete.
  modport seq (output load, output tick, output target, input done);
  modport timer (input load, input tick, input target, output done);
endinterface

// [rtl/phase_timer.sv]
// Interval timer counting PWM ticks up to a target.
`timescale 1ns/1ps
module phase_timer (
  // Clock and reset.
  input wire logic sys_clk_in,
  input wire logic rst_n_in,
  // Sequencer side.
  phase_timer_if.timer tmr
);
  import fade_pkg::*;

  // All timer state.
  typedef struct packed {
    ticks_t cnt;
  } timer_s;

  timer_s r_reg; // Registered state.
  timer_s r_next; // Next state.

  // Done marks the last tick of an interval. It must not look at load: load follows
  // the sequencer's next state, which itself follows done, and that would close a loop.
  assign tmr.done = tmr.tick && (r_reg.cnt == tmr.target - 18'h00001);

  // Count ticks; a load or a completed interval restarts from zero.
  always_comb begin
    r_next = r_reg;
    if (tmr.load || tmr.done) begin
      r_next.cnt = 18'h00000;
    end else if (tmr.tick) begin
      r_next.cnt = r_reg.cnt + 18'h00001;
    end
  end

  // State register.
  always_ff @(posedge sys_clk_in) begin
    if (!rst_n_in) begin
      r_reg <= '0;
    end else begin
      r_reg <= r_next;
    end
  end
endmodule

// [tb/host_model.sv]
// Host controller model: issues command words and supplies the external PWM clock.
`timescale 1ns/1ps
module host_model (
  // Clock.
  input wire logic sys_clk_in,
  // Command port toward the sequencer.
  output logic cmd_strobe_out,
  output logic [15:0] cmd_word_out,
  // External PWM clock pin.
  output logic ext_clk_out
);
  logic ext_run = 1'b0; // High while a sequence needs the external clock.

  // Idle levels from time zero.
  initial begin
    cmd_strobe_out = 1'b0;
    cmd_word_out = 16'h0000;
    ext_clk_out = 1'b0;
  end

  ////////////////////////////////////////////////////////////////////////////
  // One whole word per access, held until the taking edge, then scrambled.
  task automatic access(input logic rw, input logic [6:0] addr, input logic [7:0] data);
    @(posedge sys_clk_in);
    cmd_strobe_out <= 1'b1;
    cmd_word_out <= {rw, addr, data};
    @(posedge sys_clk_in);
    cmd_strobe_out <= 1'b0;
    cmd_word_out <= ~{rw, addr, data};
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // The clock keeps toggling until the sequence ends, then stands low.
  always begin
    #30;
    ext_clk_out <= ext_run ? ~ext_clk_out : 1'b0;
  end
endmodule

// [tb/testbench.sv]
// Self-checking bench for the fade sequencer.
`timescale 1ns/1ps
module testbench;
  import fade_pkg::*;
  localparam int DIV = 4; // Short internal tick divider.
  logic sys_clk_in = 1'b0;
  logic rst_n_in = 1'b0;
  logic cs_wake_in = 1'b0;
  logic pwm_in_use_in = 1'b0;
  logic cmd_strobe_in, ext_pin, shutdown_out, osc_run_out;
  logic [15:0] cmd_word_in;
  logic [7:0] rd_data_out, d;
  logic [2:0] fade_dac_out;
  logic [2:0] cap = 3'h7; // Global current the DAC must never pass.
  logic rd_flag = 1'b0; // A read was taken at the last edge.
  logic [7:0] exp_q[$]; // Expected read bytes, oldest first.
  int fails = 0;
  int checks = 0;
  int cyc_now = 0;
  int t0 = 0;
  integer seed = 32'hd46c2fd8;

  fade_sequencer #(.INT_OSC_DIV(DIV)) DUT (.sys_clk_in(sys_clk_in), .rst_n_in(rst_n_in),
    .cmd_strobe_in(cmd_strobe_in), .cmd_word_in(cmd_word_in), .rd_data_out(rd_data_out),
    .serial_out_or_clock_in_pin_in(ext_pin), .cs_wake_in(cs_wake_in),
    .pwm_in_use_in(pwm_in_use_in), .fade_dac_out(fade_dac_out),
    .shutdown_out(shutdown_out), .osc_run_out(osc_run_out));
  host_model host (.sys_clk_in(sys_clk_in), .cmd_strobe_out(cmd_strobe_in),
    .cmd_word_out(cmd_word_in), .ext_clk_out(ext_pin));

  // 100 MHz clock.
  always #5 sys_clk_in = ~sys_clk_in;

  // Cycle count and read tracking.
  always @(posedge sys_clk_in) begin
    cyc_now <= cyc_now + 1;
    rd_flag <= cmd_strobe_in & cmd_word_in[15];
  end

  ////////////////////////////////////////////////////////////////////////////
  // Watcher: pairs each read byte with the oldest note and polices the cap.
  always @(negedge sys_clk_in) begin
    if (rd_flag) begin
      if (exp_q.size() > 0) begin
        cmp("read data", exp_q.pop_front(), rd_data_out);
      end else begin
        fails++;
        $display("CHECK FAILED read queue expected note seen none");
      end
    end
    if (rst_n_in && (fade_dac_out > cap) !== 1'b0) begin
      fails++;
      $display("CHECK FAILED dac cap expected %h seen %h", cap, fade_dac_out);
    end
  end

  // Byte comparison.
  task automatic cmp(input string what, input logic [7:0] exp, input logic [7:0] got);
    checks++;
    if (got !== exp) begin
      fails++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask

  // Elapsed cycles since t0 against a figure with a tolerance.
  task automatic rng(input string what, input int exp, input int tol);
    checks++;
    if (cyc_now - t0 < exp - tol || cyc_now - t0 > exp + tol) begin
      fails++;
      $display("CHECK FAILED %s expected %0d seen %0d", what, exp, cyc_now - t0);
    end
  endtask

  // Register write, and read with its expected byte noted first.
  task automatic wr(input logic [6:0] a, input logic [7:0] v);
    host.access(1'b0, a, v);
  endtask
  task automatic rd(input logic [6:0] a, input logic [7:0] e);
    exp_q.push_back(e);
    host.access(1'b1, a, 8'h00);
  endtask

  // Checks power state and DAC once settled.
  task automatic chk(input logic sd, input logic [2:0] lv);
    #1;
    cmp("shutdown and dac", {4'h0, sd, lv}, {4'h0, shutdown_out, fade_dac_out});
  endtask

  // Bounded wait for a power state and DAC level; a lapse ends the run.
  task automatic wait_until(input logic sd, input logic [2:0] lv, input int lim);
    int k;
    k = 0;
    #1;
    while (!(shutdown_out === sd && fade_dac_out === lv)) begin
      @(posedge sys_clk_in);
      #1;
      k++;
      if (k > lim) begin
        fails++;
        $display("CHECK FAILED wait expected %h seen %h", {sd, lv}, {shutdown_out, fade_dac_out});
        finish_test();
      end
    end
  endtask

  // Cycle-count wait with no condition to hang on.
  task automatic wait_to(input int n);
    while (cyc_now - t0 < n) @(posedge sys_clk_in);
  endtask

  // Verdict and end of run.
  task automatic finish_test();
    if (exp_q.size() != 0) begin
      fails++;
      $display("CHECK FAILED read queue expected %0d seen %0d", 0, exp_q.size());
    end
    $display("checks %0d fails %0d", checks, fails);
    if (fails == 0 && checks > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // Main sequence.
  initial begin
    repeat (20) @(posedge sys_clk_in);
    rst_n_in <= 1'b1;
    // Reset values, then masked read-back of random writes and an unmapped read.
    chk(1'b1, 3'h0);
    cmp("osc enable", 8'h00, {7'h00, osc_run_out});
    rd(7'h10, 8'h00);
    rd(7'h11, 8'h00);
    rd(7'h12, 8'h00);
    rd(7'h15, 8'h07);
    d = 8'($random(seed));
    wr(7'h11, d);
    rd(7'h11, {2'b00, d[5:0]});
    wr(7'h12, d);
    rd(7'h12, {5'h00, d[2:0]});
    rd(7'h20, 8'h00);
    $display("test registers done");
    // Zero codes: instant wake and instant shutdown.
    wr(7'h11, 8'h00);
    wr(7'h12, 8'h00);
    wr(7'h10, 8'h01);
    wait_until(1'b0, 3'h7, 4);
    wr(7'h10, 8'h00);
    wait_until(1'b1, 3'h0, 4);
    $display("test zero codes done");
    // Hold then fade with the global current at 5.
    cap = 3'h5;
    wr(7'h15, 8'h05);
    wr(7'h11, 8'h09);
    wr(7'h10, 8'h01);
    wait_until(1'b0, 3'h5, 4);
    wr(7'h10, 8'h00);
    t0 = cyc_now;
    rd(7'h10, 8'h08);
    chk(1'b0, 3'h5);
    cmp("osc enable", 8'h01, {7'h00, osc_run_out});
    wait_until(1'b0, 3'h4, 12000);
    rng("first fall", (2048 + 768) * DIV, 24);
    rd(7'h10, 8'h10);
    wait_until(1'b1, 3'h0, 6000);
    rng("hold and fade", 4096 * DIV, 24);
    $display("test fade done");
    // Ramp up to the cap, status set only while ramping.
    wr(7'h12, 8'h01);
    wr(7'h10, 8'h05);
    t0 = cyc_now;
    rd(7'h10, 8'h25);
    wait_to(2048 * DIV - 40);
    rd(7'h10, 8'h25);
    chk(1'b0, 3'h5);
    wait_to(2048 * DIV + 40);
    rd(7'h10, 8'h05);
    $display("test ramp done");
    // External clock fade from run, then wake by chip-select pulse.
    cap = 3'h7;
    wr(7'h15, 8'h07);
    wr(7'h11, 8'h01);
    host.ext_run = 1'b1;
    wr(7'h10, 8'h82);
    t0 = cyc_now;
    wait_until(1'b1, 3'h0, 13000);
    rng("external fade", 2048 * 6, 40);
    host.ext_run = 1'b0;
    @(posedge sys_clk_in);
    cs_wake_in <= 1'b1;
    @(posedge sys_clk_in);
    cs_wake_in <= 1'b0;
    wait_until(1'b0, 3'h7, 6);
    rd(7'h10, 8'h83);
    repeat (3) @(posedge sys_clk_in);
    $display("test external clock and wake done");
    // Hold-off only on the internal clock: full current, then straight into shutdown.
    wr(7'h11, 8'h08);
    wr(7'h10, 8'h00);
    t0 = cyc_now;
    chk(1'b0, 3'h7);
    wait_until(1'b1, 3'h0, 8400);
    rng("hold only", 2048 * DIV, 24);
    $display("test hold only done");
    // Port PWM demand alone keeps the oscillator on in shutdown.
    @(posedge sys_clk_in);
    pwm_in_use_in <= 1'b1;
    @(posedge sys_clk_in);
    #1;
    cmp("osc enable", 8'h01, {7'h00, osc_run_out});
    @(posedge sys_clk_in);
    pwm_in_use_in <= 1'b0;
    @(posedge sys_clk_in);
    #1;
    cmp("osc enable", 8'h00, {7'h00, osc_run_out});
    $display("test oscillator demand done");
    finish_test();
  end
endmodule
